// ---- rtl/frame_readout_pkg.sv ----
// shared constants and types of the frame readout block
package frame_readout_pkg;

   // ====================================================
   // serial command and status codes
   localparam logic [7:0] OP_FRAME_READ = 8'hA6;
   localparam logic [7:0] CODE_NO_DATA = 8'h00;
   localparam logic [7:0] CODE_LEN_MIN = 8'h01;
   localparam logic [7:0] CODE_LEN_MAX = 8'hFA;
   localparam logic [7:0] CODE_TRUNCATED = 8'hFB;
   localparam logic [7:0] CODE_REDUCED = 8'hFC;
   localparam logic [7:0] CODE_PROTO_ERR = 8'hFD;
   localparam logic [7:0] CODE_BANK_BUSY = 8'hFE;
   localparam logic [7:0] CODE_NO_FRAME = 8'hFF;

   // ====================================================
   // hard error causes
   localparam logic [1:0] CAUSE_ADAPTIVE_TO = 2'h0;
   localparam logic [1:0] CAUSE_START_TO = 2'h1;
   localparam logic [1:0] CAUSE_CONTROL_TO = 2'h2;
   localparam logic [1:0] CAUSE_LEVEL_ERR = 2'h3;

   // ====================================================
   // register offsets
   localparam logic [3:0] REG_STATUS_CODE = 4'h3;
   localparam logic [3:0] REG_COUNT_LOW = 4'h4;
   localparam logic [3:0] REG_CTL_COUNT_HIGH = 4'h5;
   localparam logic [3:0] REG_ERROR_CAUSE = 4'h6;
   localparam logic [3:0] REG_CYCLE_LOW = 4'hC;
   localparam logic [3:0] REG_TIMING_HIGH = 4'hD;
   localparam logic [3:0] REG_LINE_DELAY_LOW = 4'hE;
   localparam logic [3:0] REG_PROC_TIME_LOW = 4'hF;

   // ====================================================
   // stream layout
   localparam logic [5:0] TRUNC_DATA_BYTES = 6'h20;
   localparam logic [5:0] ERROR_BYTES = 6'h01;
   localparam logic [7:0] OPTIONAL_BYTES = 8'h06;
   localparam logic [7:0] FIRST_DATA_BYTE = 8'h02;
   localparam logic [7:0] STATUS_BYTE_IDX = 8'h01;
   localparam int RAM_DEPTH = 64;
   localparam int RAM_ADDR_W = 6;

   // ====================================================
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_SYNC = 3'h0;
   localparam logic [2:0] RST_NCS_SYNC = 3'h7;

   // ====================================================
   // one processed frame as handed over by the capture engine
   typedef struct packed {
      logic [7:0] statusCode;
      logic [1:0] hardCause;
      logic warn;
      logic controlSelect;
      logic invControlMaster;
      logic [8:0] procTime;
      logic [9:0] lineDelay;
      logic [12:0] cycleTime;
   } frame_record_s;

   // frame memory write port
   typedef struct packed {
      logic en;
      logic [RAM_ADDR_W-1:0] addr;
      logic [7:0] data;
   } ram_write_s;

endpackage

// ---- rtl/frame_ram.sv ----
// two-bank frame byte memory with registered read data
`timescale 1ns/10ps
module frame_ram (
   // clock
   input wire logic mclk,
   // write side, from the capture engine
   input frame_readout_pkg::ram_write_s wr,
   // read side
   input wire logic [frame_readout_pkg::RAM_ADDR_W-1:0] rdAddr,
   output logic [7:0] rdData
);
   // ====================================================
   // storage
   logic [7:0] mem [frame_readout_pkg::RAM_DEPTH];

   always_ff @(posedge mclk) begin
      if (wr.en) begin
         mem[wr.addr] <= wr.data;
      end
   end

   // no reset on the array; read data is valid one cycle after the address
   always_ff @(posedge mclk) begin
      rdData <= mem[rdAddr];
   end

endmodule

// ---- rtl/frame_data_readout.sv ----
// serial frame-read response logic with stored-frame register view
`timescale 1ns/10ps
module frame_data_readout (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // serial port pins
   input wire logic ncsn,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   output logic misoEn,
   // capture engine side
   input frame_readout_pkg::frame_record_s frameRecord,
   input frame_readout_pkg::ram_write_s ramWrite,
   input wire logic readBank,
   input wire logic frameDetected,
   input wire logic bankBusy,
   input wire logic [13:0] lostFrameCount,
   output logic frameReadDone,
   // register view for the register-read command
   input wire logic [3:0] regAddr,
   output logic [7:0] regData
);

   // ====================================================
   // pin synchronisers
   logic [2:0] ncsSync_q;
   logic [2:0] sclkSync_q;
   logic [1:0] mosiSync_q;

   // third stage only feeds the edge detector, the first stays private
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ncsSync_q <= frame_readout_pkg::RST_NCS_SYNC;
         sclkSync_q <= frame_readout_pkg::RST_SYNC;
         mosiSync_q <= 2'h0;
      end else begin
         ncsSync_q <= {ncsSync_q[1:0], ncsn};
         sclkSync_q <= {sclkSync_q[1:0], sclk};
         mosiSync_q <= {mosiSync_q[0], mosi};
      end
   end

   wire selected = !ncsSync_q[1];
   wire selEnd = ncsSync_q[1] && !ncsSync_q[2];
   wire sclkRise = sclkSync_q[1] && !sclkSync_q[2] && selected;
   wire sclkFall = !sclkSync_q[1] && sclkSync_q[2] && selected;
   wire mosiBit = mosiSync_q[1];

   // ====================================================
   // live register values
   wire [7:0] statusNow = !frameDetected ? frame_readout_pkg::CODE_NO_FRAME :
                          bankBusy ? frame_readout_pkg::CODE_BANK_BUSY :
                          frameRecord.statusCode;
   wire [7:0] countLowNow = lostFrameCount[7:0];
   wire [7:0] ctlCountNow = {frameRecord.controlSelect, frameRecord.invControlMaster,
                             lostFrameCount[13:8]};
   wire [7:0] causeNow = {5'h00, frameRecord.hardCause, frameRecord.warn};
   wire [7:0] cycleLowNow = frameRecord.cycleTime[7:0];
   wire [7:0] timingHighNow = {frameRecord.procTime[8], frameRecord.lineDelay[9:8],
                               frameRecord.cycleTime[12:8]};
   wire [7:0] delayLowNow = frameRecord.lineDelay[7:0];
   wire [7:0] procLowNow = frameRecord.procTime[7:0];

   // ====================================================
   // register read decode
   wire [7:0] regSel = (regAddr == frame_readout_pkg::REG_STATUS_CODE) ? statusNow :
                       (regAddr == frame_readout_pkg::REG_COUNT_LOW) ? countLowNow :
                       (regAddr == frame_readout_pkg::REG_CTL_COUNT_HIGH) ? ctlCountNow :
                       (regAddr == frame_readout_pkg::REG_ERROR_CAUSE) ? causeNow :
                       (regAddr == frame_readout_pkg::REG_CYCLE_LOW) ? cycleLowNow :
                       (regAddr == frame_readout_pkg::REG_TIMING_HIGH) ? timingHighNow :
                       (regAddr == frame_readout_pkg::REG_LINE_DELAY_LOW) ? delayLowNow :
                       (regAddr == frame_readout_pkg::REG_PROC_TIME_LOW) ? procLowNow :
                       frame_readout_pkg::RST_BYTE;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         regData <= frame_readout_pkg::RST_BYTE;
      end else begin
         regData <= regSel;
      end
   end

   // ====================================================
   // receive side: bit and byte counting
   logic [2:0] bitCnt_q;
   logic [7:0] byteCnt_q;
   logic [6:0] rxShift_q;
   logic cmdOk_q;

   wire byteDone = sclkRise && (bitCnt_q == 3'h7);
   wire [7:0] rxByte = {rxShift_q, mosiBit};
   wire opcodeHit = byteDone && (byteCnt_q == 8'h00) && (rxByte == frame_readout_pkg::OP_FRAME_READ);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bitCnt_q <= 3'h0;
         rxShift_q <= 7'h00;
      end else if (!selected) begin
         bitCnt_q <= 3'h0;
      end else if (sclkRise) begin
         bitCnt_q <= bitCnt_q + 3'h1;
         rxShift_q <= rxByte[6:0];
      end
   end

   // saturates so a long clock-out just keeps sending zeros
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         byteCnt_q <= 8'h00;
      end else if (!selected) begin
         byteCnt_q <= 8'h00;
      end else if (byteDone && byteCnt_q != 8'hFF) begin
         byteCnt_q <= byteCnt_q + 8'h01;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cmdOk_q <= 1'b0;
      end else if (!selected) begin
         cmdOk_q <= 1'b0;
      end else if (opcodeHit) begin
         cmdOk_q <= 1'b1;
      end
   end

   // ====================================================
   // snapshot at the opcode, so the stream cannot tear mid-transfer
   logic [7:0] statusQ_q;
   logic [7:0] causeQ_q;
   logic [47:0] optWord_q;
   logic bankQ_q;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         statusQ_q <= frame_readout_pkg::CODE_NO_FRAME;
         causeQ_q <= frame_readout_pkg::RST_BYTE;
         optWord_q <= 48'h000000000000;
         bankQ_q <= 1'b0;
      end else if (opcodeHit) begin
         statusQ_q <= statusNow;
         causeQ_q <= causeNow;
         optWord_q <= {ctlCountNow, countLowNow,
                       frameRecord.procTime, frameRecord.lineDelay, frameRecord.cycleTime};
         bankQ_q <= readBank;
      end
   end

   // ====================================================
   // stream layout after the status byte
   wire [8:0] lenRound = {1'b0, statusQ_q} + 9'h007;
   wire isLength = (statusQ_q >= frame_readout_pkg::CODE_LEN_MIN) &&
                   (statusQ_q <= frame_readout_pkg::CODE_LEN_MAX);
   wire isTrunc = statusQ_q == frame_readout_pkg::CODE_TRUNCATED;
   wire isError = statusQ_q == frame_readout_pkg::CODE_PROTO_ERR;
   wire isNoFrame = statusQ_q == frame_readout_pkg::CODE_NO_FRAME;
   // control-only, reduced and busy all carry zero data bytes
   wire [5:0] dataBytes = isLength ? lenRound[8:3] :
                          isTrunc ? frame_readout_pkg::TRUNC_DATA_BYTES :
                          isError ? frame_readout_pkg::ERROR_BYTES :
                          6'h00;
   wire [7:0] relIdx = byteCnt_q - frame_readout_pkg::FIRST_DATA_BYTE;
   wire pastStatus = byteCnt_q >= frame_readout_pkg::FIRST_DATA_BYTE;
   wire inData = pastStatus && (relIdx < {2'h0, dataBytes});
   wire [7:0] optIdx = relIdx - {2'h0, dataBytes};
   wire inOpt = pastStatus && !inData && (optIdx < frame_readout_pkg::OPTIONAL_BYTES);

   // ====================================================
   // frame memory
   logic [4:0] dataIdx_q;
   logic [7:0] ramData;
   wire [frame_readout_pkg::RAM_ADDR_W-1:0] ramAddr = {bankQ_q, dataIdx_q};

   frame_ram frame_ram_i (
      .mclk(mclk),
      .wr(ramWrite),
      .rdAddr(ramAddr),
      .rdData(ramData)
   );

   // ====================================================
   // next transmit byte
   wire [7:0] optByte = (optIdx == 8'h00) ? optWord_q[47:40] :
                        (optIdx == 8'h01) ? optWord_q[39:32] :
                        (optIdx == 8'h02) ? optWord_q[31:24] :
                        (optIdx == 8'h03) ? optWord_q[23:16] :
                        (optIdx == 8'h04) ? optWord_q[15:8] :
                        optWord_q[7:0];
   // memory bytes go out as stored, bit order inside is the capture engine's
   wire [7:0] dataByte = isError ? causeQ_q : ramData;
   wire [7:0] nextByte = (byteCnt_q == frame_readout_pkg::STATUS_BYTE_IDX) ? statusQ_q :
                         isNoFrame ? frame_readout_pkg::RST_BYTE :
                         inData ? dataByte :
                         inOpt ? optByte :
                         frame_readout_pkg::RST_BYTE;
   wire loadByte = sclkFall && (bitCnt_q == 3'h0) && cmdOk_q;
   wire loadRam = loadByte && inData && !isError && !isNoFrame;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dataIdx_q <= 5'h00;
      end else if (!selected) begin
         dataIdx_q <= 5'h00;
      end else if (loadRam) begin
         dataIdx_q <= dataIdx_q + 5'h01;
      end
   end

   // ====================================================
   // transmit shifter
   logic [7:0] txShift_q;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         txShift_q <= frame_readout_pkg::RST_BYTE;
      end else if (!selected) begin
         txShift_q <= frame_readout_pkg::RST_BYTE;
      end else if (loadByte) begin
         txShift_q <= nextByte;
      end else if (sclkFall) begin
         txShift_q <= {txShift_q[6:0], 1'b0};
      end
   end

   assign miso = txShift_q[7];
   // pin released while deselected so other devices can share the line
   assign misoEn = selected;

   // ====================================================
   // completion: status byte fully sent and a frame was there
   wire readSuccess = selEnd && cmdOk_q && (byteCnt_q >= frame_readout_pkg::FIRST_DATA_BYTE) && !isNoFrame;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         frameReadDone <= 1'b0;
      end else begin
         frameReadDone <= readSuccess;
      end
   end

endmodule

// ---- sim/frame_data_readout_sva.sv ----
// port checks of the frame readout block
`timescale 1ns/10ps
module frame_data_readout_sva (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // serial pins
   input wire logic ncsn,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso,
   input wire logic misoEn,
   // capture engine side
   input frame_readout_pkg::frame_record_s frameRecord,
   input frame_readout_pkg::ram_write_s ramWrite,
   input wire logic readBank,
   input wire logic frameDetected,
   input wire logic bankBusy,
   input wire logic [13:0] lostFrameCount,
   input wire logic frameReadDone,
   // register view
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regData
);
   // ========
   // last edge's inputs, the view lags one cycle
   frame_readout_pkg::frame_record_s rec_q;
   logic [13:0] cnt_q;
   wire [7:0] ctlByte = {rec_q.controlSelect, rec_q.invControlMaster, cnt_q[13:8]};
   always_ff @(posedge mclk) begin
      rec_q <= frameRecord;
      cnt_q <= lostFrameCount;
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // ========
   // register view and link
   a_none_code: assert property (regAddr == 4'h3 && !frameDetected |=> regData == 8'hFF)
      else $error("status not none");
   a_busy_code: assert property (regAddr == 4'h3 && frameDetected && bankBusy |=> regData == 8'hFE)
      else $error("status not busy");
   a_stored_code: assert property (regAddr == 4'h3 && frameDetected && !bankBusy |=> regData == rec_q.statusCode)
      else $error("status not stored code");
   a_count_low: assert property (regAddr == 4'h4 |=> regData == cnt_q[7:0])
      else $error("count low wrong");
   a_ctl_high: assert property (regAddr == 4'h5 |=> regData == ctlByte)
      else $error("control byte wrong");
   a_cause_reg: assert property (regAddr == 4'h6 |=> regData == {5'h00, rec_q.hardCause, rec_q.warn})
      else $error("cause byte wrong");
   a_proc_low: assert property (regAddr == 4'hF |=> regData == rec_q.procTime[7:0])
      else $error("processing time wrong");
   a_timing_high: assert property (regAddr == 4'hD |=> regData == {rec_q.procTime[8], rec_q.lineDelay[9:8], rec_q.cycleTime[12:8]})
      else $error("timing high byte wrong");
   a_delay_low: assert property (regAddr == 4'hE |=> regData == rec_q.lineDelay[7:0])
      else $error("line delay wrong");
   a_cycle_low: assert property (regAddr == 4'hC |=> regData == rec_q.cycleTime[7:0])
      else $error("cycle time wrong");
   a_unmapped_zero: assert property (regAddr < 4'h3 |=> regData == 8'h00)
      else $error("unmapped address not zero");
   a_sel_release: assert property (ncsn [*4] |-> !misoEn && !miso)
      else $error("output active while deselected");
   a_done_pulse: assert property (frameReadDone |=> !frameReadDone)
      else $error("done longer than a cycle");
   c_read_done: cover property (frameReadDone);
   c_busy_seen: cover property (regAddr == 4'h3 && frameDetected && bankBusy);
   c_select: cover property ($fell(ncsn) ##[1:3] misoEn);
endmodule

// ---- sim/spi_host_model.sv ----
// host side serial master, mode 0
`timescale 1ns/10ps
module spi_host_model (
   // serial pins
   output logic ncsn = 1'b1,
   output logic sclk = 1'b0,
   output logic mosi = 1'b1,
   input wire logic miso,
   // bytes taken after the opcode
   output logic [7:0] rxByte = 8'h00,
   output logic rxStb = 1'b0
);
   // ========
   // one transfer; miso taken late in the high phase so the slow output has settled
   task automatic xfer(input logic [7:0] op, input int n);
      logic [7:0] tx;
      ncsn = 1'b0;
      #1000;
      for (int b = 0; b < n; b++) begin
         tx = (b == 0) ? op : 8'($urandom);
         for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #400 sclk = 1'b1;
            #390 rxByte[i] = miso;
            #10 sclk = 1'b0;
         end
         rxStb = (b > 0);
         #1 rxStb = 1'b0;
      end
      #400 ncsn = 1'b1;
      mosi = ~mosi;
      #1000;
   endtask
endmodule

// ---- sim/tb_frame_data_readout.sv ----
// self-checking bench of the frame readout block
`timescale 1ns/10ps
module tb_frame_data_readout;
   // ========
   // signals
   logic mclk, ncsn, sclk, mosi, miso, misoEn, frameReadDone, rxStb;
   logic rstn = 1'b0;
   frame_readout_pkg::frame_record_s rec = '0;
   frame_readout_pkg::ram_write_s ramWrite = '0;
   logic readBank = 1'b0;
   logic frameDetected = 1'b0;
   logic bankBusy = 1'b0;
   logic [13:0] lostFrameCount = 14'h0000;
   logic [3:0] regAddr = 4'h0;
   logic [1:0] causeSel = 2'h0;
   logic [7:0] regData, rxByte;
   logic [7:0] expQ[$];
   logic [7:0] mem[64];
   int err_count = 0;
   int checked = 0;
   int doneCnt = 0;
   int cycles = 0;
   frame_data_readout frame_data_readout_i (.mclk(mclk), .rstn(rstn), .ncsn(ncsn), .sclk(sclk), .mosi(mosi),
      .miso(miso), .misoEn(misoEn), .frameRecord(rec), .ramWrite(ramWrite), .readBank(readBank),
      .frameDetected(frameDetected), .bankBusy(bankBusy), .lostFrameCount(lostFrameCount),
      .frameReadDone(frameReadDone), .regAddr(regAddr), .regData(regData));
   spi_host_model spi_host_model_i (.ncsn(ncsn), .sclk(sclk), .mosi(mosi), .miso(miso), .rxByte(rxByte),
      .rxStb(rxStb));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // ========
   // compare, verdict, watchdog
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge rxStb) begin
      chk("stream byte", (expQ.size() > 0) ? expQ.pop_front() : 8'hXX, rxByte);
   end
   always @(posedge mclk) begin
      cycles++;
      if (frameReadDone === 1'b1) doneCnt++;
      if (cycles == 40000) begin
         err_count++;
         report_and_stop();
      end
   end
   // ========
   // one frame: load it, sweep the register view, read it over the link
   task automatic run(input logic [7:0] code, input logic det, input logic busy, input logic [7:0] op, input int cut);
      logic [7:0] st;
      logic ok;
      int nd;
      int d0;
      readBank = ~readBank;
      for (int a = 0; a < 64; a++) begin
         mem[a] = 8'($urandom);
         ramWrite = '{1'b1, 6'(a), mem[a]};
         @(posedge mclk) #10;
      end
      ramWrite.en = 1'b0;
      rec = {code, 37'({$urandom, $urandom})};
      rec.hardCause = causeSel;
      causeSel = causeSel + 2'h1;
      lostFrameCount = 14'($urandom);
      frameDetected = det;
      bankBusy = busy;
      for (int a = 0; a < 20; a++) begin
         regAddr = 4'(a);
         @(posedge mclk) #10;
      end
      st = !det ? 8'hFF : (busy ? 8'hFE : code);
      chk("status register", st, regData);
      nd = (st == 8'hFD) ? 1 : (st == 8'hFB) ? 32 : (st != 8'h00 && st < 8'hFB) ? (st + 7) / 8 : 0;
      ok = (op == frame_readout_pkg::OP_FRAME_READ);
      if (!ok) begin
         st = 8'h00;
         nd = 6;
      end
      expQ.push_back(st);
      for (int i = 0; i < nd; i++) begin
         expQ.push_back(st == 8'hFD ? {5'h00, rec.hardCause, rec.warn} :
            (st == 8'h00 ? 8'h00 : mem[{readBank, 5'(i)}]));
      end
      if (st != 8'hFF && ok) begin
         expQ.push_back({rec.controlSelect, rec.invControlMaster, lostFrameCount[13:8]});
         expQ.push_back(lostFrameCount[7:0]);
         expQ.push_back(rec.procTime[8:1]);
         expQ.push_back({rec.procTime[0], rec.lineDelay[9:3]});
         expQ.push_back({rec.lineDelay[2:0], rec.cycleTime[12:8]});
         expQ.push_back(rec.cycleTime[7:0]);
      end
      expQ.push_back(8'h00);
      while (cut > 0 && expQ.size() > cut - 1) begin
         void'(expQ.pop_back());
      end
      d0 = doneCnt;
      spi_host_model_i.xfer(op, expQ.size() + 1);
      repeat (5) @(posedge mclk) #10;
      chk("done pulses", 8'((ok && st != 8'hFF) ? 1 : 0), 8'(doneCnt - d0));
      chk("bytes left", 8'h00, 8'(expQ.size()));
      $display("test with code %h opcode %h ended", code, op);
   endtask
   initial begin
      void'($urandom(4840));
      repeat (12) @(posedge mclk);
      #10;
      rstn = 1'b1;
      repeat (4) @(posedge mclk) #10;
      run(8'h00, 1'b1, 1'b0, frame_readout_pkg::OP_FRAME_READ, 0);
      run(8'($urandom_range(1, 249)), 1'b1, 1'b0, frame_readout_pkg::OP_FRAME_READ, 0);
      run(8'hFA, 1'b1, 1'b0, frame_readout_pkg::OP_FRAME_READ, 0);
      run(8'hFB, 1'b1, 1'b0, frame_readout_pkg::OP_FRAME_READ, 0);
      run(8'hFC, 1'b1, 1'b0, frame_readout_pkg::OP_FRAME_READ, 0);
      repeat (4) run(8'hFD, 1'b1, 1'b0, frame_readout_pkg::OP_FRAME_READ, 0);
      run(8'h40, 1'b1, 1'b1, frame_readout_pkg::OP_FRAME_READ, 0);
      run(8'h40, 1'b0, 1'b0, frame_readout_pkg::OP_FRAME_READ, 0);
      run(8'h40, 1'b1, 1'b0, 8'h9C, 0);
      run(8'hFA, 1'b1, 1'b0, frame_readout_pkg::OP_FRAME_READ, 5);
      report_and_stop();
   end
endmodule
bind frame_data_readout frame_data_readout_sva frame_data_readout_sva_i (.mclk(mclk), .rstn(rstn), .ncsn(ncsn),
   .sclk(sclk), .mosi(mosi), .miso(miso), .misoEn(misoEn), .frameRecord(frameRecord), .ramWrite(ramWrite),
   .readBank(readBank), .frameDetected(frameDetected), .bankBusy(bankBusy), .lostFrameCount(lostFrameCount),
   .frameReadDone(frameReadDone), .regAddr(regAddr), .regData(regData));
